// >>> logic/asbl_ctrl.sv
// Functional notes
// - write only while select, strobe, lane low
// - data stable 5 ns before, 0 after end
// - write strobe high throughout every read
// - strobe write cycle at least float+setup
// - wait 1 us after power before access
// - read cycle 10 ns, data valid 10 ns
// - address 7 ns before end, 0 after
// - strobes low 7 ns, write cycle 10 ns
`include "asbl_params.svh"
module asbl_ctrl
#(
  parameter int unsigned POWER_ON_CYC = `ASBL_POWER_ON_CYC
)
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [16:0] req_addr,
  input  wire logic [15:0] req_wdata,
  input  wire logic [1:0]  req_lane_n,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic      [15:0] rsp_rdata,
  output logic      [16:0] mem_addr,
  output logic             chip_sel_n,
  output logic             out_gate_n,
  output logic             write_strobe_n,
  output logic             low_lane_sel_n,
  output logic             high_lane_sel_n,
  input  wire logic [15:0] data_in,
  output logic      [15:0] data_out,
  output logic      [1:0]  data_oe_n
);
  localparam logic [7:0] RD_CYC = 8'(`ASBL_RD_CYC);
  localparam logic [7:0] WR_CYC = 8'(`ASBL_WR_CYC);
  localparam logic [7:0] IDLE_CYC = 8'(`ASBL_IDLE_CYC);

  asbl_pkg::asbl_state_t state;
  asbl_pkg::asbl_state_t next_state;
  logic [19:0] pwr_cnt;
  logic [7:0]  cnt;
  logic [15:0] sync_data;
  logic        is_wr;

  asbl_sync u_sync
  (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .din     (data_in),
    .dout    (sync_data)
  );

  wire pwr_done = (pwr_cnt >= 20'(POWER_ON_CYC));
  wire cnt_done = (cnt == 8'h01);
  wire take = (state == asbl_pkg::ASBL_IDLE) && req_valid && cnt_done;
  // a request with no lane selected would be an empty access
  wire lane_any = ~&req_lane_n;
  wire go_rd    = (state == asbl_pkg::ASBL_IDLE) &&
                  (next_state == asbl_pkg::ASBL_READ);
  wire go_wr    = (state == asbl_pkg::ASBL_IDLE) &&
                  (next_state == asbl_pkg::ASBL_WRITE);

  always_comb
  begin
    next_state = state;
    case (state)
      asbl_pkg::ASBL_POWER:
        if (pwr_done)
          next_state = asbl_pkg::ASBL_IDLE;
      asbl_pkg::ASBL_IDLE:
        if (take && lane_any)
          next_state = req_write ? asbl_pkg::ASBL_WRITE
                                 : asbl_pkg::ASBL_READ;
      asbl_pkg::ASBL_READ:
        if (cnt_done)
          next_state = asbl_pkg::ASBL_RECOV;
      asbl_pkg::ASBL_WRITE:
        if (cnt_done)
          next_state = asbl_pkg::ASBL_RECOV;
      asbl_pkg::ASBL_RECOV:
        next_state = asbl_pkg::ASBL_IDLE;
      default:
        next_state = asbl_pkg::ASBL_POWER;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      pwr_cnt <= 20'h0_0000;
    else if (!pwr_done)
      pwr_cnt <= pwr_cnt + 20'h0_0001;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      state <= asbl_pkg::ASBL_POWER;
    else
      state <= next_state;
  end

  // one counter times read cycle, write pulse and deselect gap
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      cnt <= 8'h01;
    else if (go_rd)
      cnt <= RD_CYC;
    else if (go_wr)
      cnt <= WR_CYC;
    else if (state == asbl_pkg::ASBL_RECOV)
      cnt <= IDLE_CYC;
    else if (!cnt_done)
      cnt <= cnt - 8'h01;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      mem_addr        <= 17'h0_0000;
      data_out        <= 16'h0000;
      is_wr           <= 1'b0;
      low_lane_sel_n  <= 1'b1;
      high_lane_sel_n <= 1'b1;
    end
    else if (take && lane_any)
    begin
      // address and data set on the edge the strobes fall, held past rise
      mem_addr        <= req_addr;
      data_out        <= req_wdata;
      is_wr           <= req_write;
      low_lane_sel_n  <= req_lane_n[0];
      high_lane_sel_n <= req_lane_n[1];
    end
  end

  wire active = (state == asbl_pkg::ASBL_READ) ||
                (state == asbl_pkg::ASBL_WRITE);
  wire wr_act = (state == asbl_pkg::ASBL_WRITE);
  wire rd_act = (state == asbl_pkg::ASBL_READ);

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      chip_sel_n     <= 1'b1;
      out_gate_n     <= 1'b1;
      write_strobe_n <= 1'b1;
      data_oe_n      <= 2'b11;
    end
    else
    begin
      // select held one cycle past strobe so strobe ends the write
      chip_sel_n     <= ~(next_state == asbl_pkg::ASBL_READ ||
                          next_state == asbl_pkg::ASBL_WRITE ||
                          (wr_act && cnt_done));
      out_gate_n     <= ~(next_state == asbl_pkg::ASBL_READ);
      write_strobe_n <= ~(next_state == asbl_pkg::ASBL_WRITE);
      // drive only the lanes written; data held one cycle past strobe
      data_oe_n[0] <= ~((next_state == asbl_pkg::ASBL_WRITE ||
                         (wr_act && cnt_done)) &&
                        ~(take ? req_lane_n[0] : low_lane_sel_n));
      data_oe_n[1] <= ~((next_state == asbl_pkg::ASBL_WRITE ||
                         (wr_act && cnt_done)) &&
                        ~(take ? req_lane_n[1] : high_lane_sel_n));
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
      req_ready <= 1'b0;
    end
    else
    begin
      rsp_valid <= (active && cnt_done) || (take && !lane_any);
      // unread lane returns zero since the memory floats it
      rsp_rdata <= (rd_act && cnt_done) ?
                   {high_lane_sel_n ? 8'h00 : sync_data[15:8],
                    low_lane_sel_n ? 8'h00 : sync_data[7:0]}
                   : 16'h0000;
      req_ready <= (next_state == asbl_pkg::ASBL_IDLE) && !take &&
                   (state != asbl_pkg::ASBL_RECOV) &&
                   (cnt_done || cnt == 8'h02);
    end
  end
  wire unused_ok = is_wr;
endmodule

// >>> logic/asbl_params.svh
`ifndef ASBL_PARAMS_SVH
`define ASBL_PARAMS_SVH

`define ASBL_ADDR_W        17
`define ASBL_DATA_W        16
`define ASBL_CLK_PS        8000
`define ASBL_POWER_ON_US   1
`define ASBL_POWER_ON_PS   (`ASBL_POWER_ON_US * 1000000)
`define ASBL_POWER_ON_CYC  ((`ASBL_POWER_ON_PS + `ASBL_CLK_PS - 1) / `ASBL_CLK_PS)
`define ASBL_READ_CYC_NS   10
`define ASBL_ADDR_VALID_NS 10
`define ASBL_WE_PULSE_NS   7
`define ASBL_WR_CYC_NS     10
`define ASBL_FLOAT_NS      5
`define ASBL_SETUP_NS      5
`define ASBL_DESEL_NS      10
`define ASBL_CYC(ns)       (((ns) * 1000 + `ASBL_CLK_PS - 1) / `ASBL_CLK_PS)
`define ASBL_RD_CYC        (`ASBL_CYC(`ASBL_ADDR_VALID_NS) + 2)
`define ASBL_WR_CYC        `ASBL_CYC(`ASBL_FLOAT_NS + `ASBL_SETUP_NS)
`define ASBL_IDLE_CYC      `ASBL_CYC(`ASBL_DESEL_NS)

`endif

// >>> logic/asbl_pkg.sv
package asbl_pkg;
  typedef enum logic [2:0]
  {
    ASBL_POWER = 3'h0,
    ASBL_IDLE  = 3'h1,
    ASBL_READ  = 3'h3,
    ASBL_WRITE = 3'h2,
    ASBL_RECOV = 3'h6
  } asbl_state_t;
endpackage

// >>> logic/asbl_sync.sv
module asbl_sync
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] din,
  output logic      [15:0] dout
);
  logic [15:0] meta;

  // pins change without regard to mclk
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      meta <= 16'h0000;
      dout <= 16'h0000;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// >>> testbench/asbl_ctrl_properties.sv
module asbl_chk
#(
  parameter int unsigned POWER_ON_CYC = 4
)
(
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic [16:0] mem_addr,
  input wire logic        chip_sel_n,
  input wire logic        out_gate_n,
  input wire logic        write_strobe_n,
  input wire logic        low_lane_sel_n,
  input wire logic        high_lane_sel_n,
  input wire logic [15:0] data_out,
  input wire logic [1:0]  data_oe_n
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  int unsigned up;
  // counts from reset release; the supply ramp is not visible here
  always_ff @(posedge mclk)
    if (sys_rst)
      up <= 0;
    else if (up < POWER_ON_CYC)
      up <= up + 1;
  pwr_wait_a:
    assert property (up < POWER_ON_CYC |-> chip_sel_n)
    else $error("access before power wait");
  read_strobe_a:
    assert property (!chip_sel_n && !out_gate_n |-> write_strobe_n)
    else $error("strobe low in read");
  write_sel_a:
    assert property (!write_strobe_n |->
      !chip_sel_n && !(low_lane_sel_n && high_lane_sel_n))
    else $error("write without select");
  lane_drive_a:
    assert property (!write_strobe_n |->
      data_oe_n == {high_lane_sel_n, low_lane_sel_n})
    else $error("driven lanes differ");
  strobe_width_a:
    assert property ($fell(write_strobe_n) |=> !write_strobe_n)
    else $error("strobe pulse short");
  write_cycle_a:
    assert property ($fell(write_strobe_n) |-> !chip_sel_n [*3])
    else $error("write cycle short");
  addr_hold_a:
    assert property ($rose(write_strobe_n) |->
      $stable(mem_addr) && $stable(data_out))
    else $error("address or data moved");
  read_len_a:
    assert property ($fell(out_gate_n) |=> !out_gate_n && !chip_sel_n)
    else $error("read cycle short");
endmodule
bind asbl_ctrl asbl_chk #(.POWER_ON_CYC(POWER_ON_CYC)) u_chk (.mclk,
  .sys_rst, .mem_addr, .chip_sel_n, .out_gate_n, .write_strobe_n,
  .low_lane_sel_n, .high_lane_sel_n, .data_out, .data_oe_n);

// >>> testbench/asbl_ctrl_tb.sv
module asbl_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0;
  logic        sys_rst = 1;
  logic        req_valid = 0;
  logic        req_write = 0;
  logic [16:0] req_addr = 17'h0_0000;
  logic [15:0] req_wdata = 16'h0000;
  logic [1:0]  req_lane_n = 2'h3;
  logic        req_ready, rsp_valid, chip_sel_n, out_gate_n, write_strobe_n;
  logic        low_lane_sel_n, high_lane_sel_n;
  logic [15:0] rsp_rdata, data_out, data_in;
  logic [16:0] mem_addr;
  logic [1:0]  data_oe_n;
  logic [15:0] ref_mem [int];
  logic [15:0] exp_q [$];
  logic [31:0] lfsr = 32'h0001_43D0;
  int          bad_count = 0;
  int          n_tests = 0;
  always #4 mclk = ~mclk;
  asbl_ctrl #(.POWER_ON_CYC(4)) DUT (.mclk, .sys_rst, .req_valid, .req_write,
    .req_addr, .req_wdata, .req_lane_n, .req_ready, .rsp_valid, .rsp_rdata,
    .mem_addr, .chip_sel_n, .out_gate_n, .write_strobe_n, .low_lane_sel_n,
    .high_lane_sel_n, .data_in, .data_out, .data_oe_n);
  asbl_sram_model u_mem (.mclk, .mem_addr, .chip_sel_n, .out_gate_n,
    .write_strobe_n, .low_lane_sel_n, .high_lane_sel_n, .data_out,
    .data_oe_n, .data_in);
  task automatic chk(input string nm, input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic [16:0] a, input logic [1:0] l);
    int k;
    @(posedge mclk);
    #1;
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    req_write = w;
    req_addr = a;
    req_wdata = lfsr[15:0];
    req_lane_n = l;
    req_valid = 1;
    k = 0;
    @(posedge mclk);
    while (req_ready !== 1'b1 && ++k < 300)
      @(posedge mclk);
    if (k >= 300)
      bad_count++;
    #1;
    req_valid = 0;
    if (w)
      ref_mem[a] = {l[1] ? ref_mem[a][15:8] : req_wdata[15:8],
                    l[0] ? ref_mem[a][7:0] : req_wdata[7:0]};
    exp_q.push_back(w ? 16'h0000 : {l[1] ? 8'h00 : ref_mem[a][15:8],
                                    l[0] ? 8'h00 : ref_mem[a][7:0]});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(negedge mclk)
    if (rsp_valid === 1'b1)
      chk("rsp_rdata", rsp_rdata, exp_q.pop_front());
  initial
  begin
    logic [16:0] ad;
    repeat (10) @(posedge mclk);
    #1;
    sys_rst = 0;
    // first request lands inside the power-up wait on purpose
    for (int i = 0; i < 3; i++)
    begin
      ad = (i == 0) ? lfsr[16:0] : {17{i[1]}};
      for (int l = 0; l < 8; l++)
        acc(l < 4, ad, l[1:0]);
    end
    repeat (20) @(posedge mclk);
    chk("pending", 16'(exp_q.size()), 16'h0000);
    report_and_stop;
  end
  initial
  begin
    #100000;
    bad_count++;
    report_and_stop;
  end
endmodule

// >>> testbench/asbl_sram_model.sv
module asbl_sram_model
(
  input  wire logic        mclk,
  input  wire logic [16:0] mem_addr,
  input  wire logic        chip_sel_n,
  input  wire logic        out_gate_n,
  input  wire logic        write_strobe_n,
  input  wire logic        low_lane_sel_n,
  input  wire logic        high_lane_sel_n,
  input  wire logic [15:0] data_out,
  input  wire logic [1:0]  data_oe_n,
  output logic      [15:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:131071];
  logic [15:0] last = 16'h0000;
  logic [1:0]  sel;
  logic [1:0]  wr;
  logic [1:0]  rd;
  assign sel = {!high_lane_sel_n, !low_lane_sel_n} & {2{!chip_sel_n}};
  assign wr = sel & {2{!write_strobe_n}};
  assign rd = sel & {2{write_strobe_n && !out_gate_n}};
  // floating lanes toggle so a stale value never reads back
  assign data_in[7:0] = !data_oe_n[0] ? data_out[7:0]
    : rd[0] ? mem[mem_addr][7:0] : ~last[7:0];
  assign data_in[15:8] = !data_oe_n[1] ? data_out[15:8]
    : rd[1] ? mem[mem_addr][15:8] : ~last[15:8];
  always @(posedge mclk)
    last <= data_in;
  always @*
    if (wr[0])
      mem[mem_addr][7:0] = data_in[7:0];
  always @*
    if (wr[1])
      mem[mem_addr][15:8] = data_in[15:8];
endmodule
